// ===== core/clock_system.sv
// clock source selection, backup fallback, prescaler and register port
// assumes oscillator levels and configuration inputs are synchronous to
// aclk, and an AXI4-Lite master on the register port
//
// Operation
// R1: prescaler divides source by 2 to 512
// R2: double speed bypasses prescaler, six periods
// R3: twelve to 256*12 source periods per instruction
// R4: crystal enable gates crystal or external input
// R5: fast rc enable gates 12 MHz rc
// R6: source select picks crystal or fast rc
// R7: both disabled falls back to slow rc
// R8: slow rc always clocks watchdog, strap disables
// R9: reset source comes from configuration strap
// R10: gain strap picks 32 kHz or 33 MHz
// R11: unselected crystal releases pins to gpio
// R12: select one is crystal, zero fast rc
// R13: strap one starts crystal, zero rc
// R14: reload 00h divides 512, FFh divides 2
// R15: source switching is glitch free
// R16: divide factor is 2*(256-reload), balanced
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module clock_system
  import clock_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // register port
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // configuration byte straps
  input  wire logic        cfg_reset_osc,
  input  wire logic        cfg_crystal_gain,
  input  wire logic        cfg_slow_rc_disable,
  // sampled oscillator levels
  input  wire logic        crystal_oscillator,
  input  wire logic        fast_rc_oscillator,
  input  wire logic        slow_rc_oscillator,
  // oscillator controls
  output logic             xtal_osc_run,
  output logic             fast_rc_run,
  output logic             slow_rc_run,
  output logic             crystal_gain_select,
  output logic             crystal_pins_released,
  // clocks to the core
  output logic             watchdog_clk,
  output logic             cpu_clk,
  output logic             machine_cycle
);

  // ------------------------------------------------------------------
  // control state
  // ------------------------------------------------------------------
  logic       xtal_osc_enable;
  logic       fast_rc_enable;
  logic       clock_source_select;
  logic       double_speed_bypass;
  logic [7:0] prescaler_reload;
  logic       slow_rc_disable;
  logic       strap_reset_osc;
  logic       straps_loaded;

  // ------------------------------------------------------------------
  // bus state
  // ------------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  function automatic logic reg_known(input logic [7:0] addr);
    reg_known = (addr == OSC_CTRL_ADDR)   || (addr == SPEED_CTRL_ADDR) ||
                (addr == RELOAD_ADDR)     || (addr == CLK_STATUS_ADDR);
  endfunction

  // ------------------------------------------------------------------
  // strap capture after reset release
  // ------------------------------------------------------------------
  // the straps are latched one edge after reset leaves, so no register
  // takes a port value under reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      straps_loaded       <= 1'b0;
      strap_reset_osc     <= 1'b0;
      crystal_gain_select <= 1'b0;
      slow_rc_disable     <= 1'b0;
    end
    else if (!straps_loaded)
    begin
      straps_loaded       <= 1'b1;
      strap_reset_osc     <= cfg_reset_osc;              // see R9
      crystal_gain_select <= cfg_crystal_gain;           // see R10
      slow_rc_disable     <= cfg_slow_rc_disable;        // see R8
    end
  end

  // ------------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------------
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire do_write  = aw_held & w_held & ~s_axi_bvalid;
  wire wr_lane0  = w_strb[0];
  wire wr_osc    = do_write & wr_lane0 & (aw_addr == OSC_CTRL_ADDR);
  wire wr_speed  = do_write & wr_lane0 & (aw_addr == SPEED_CTRL_ADDR);
  wire wr_reload = do_write & wr_lane0 & (aw_addr == RELOAD_ADDR);

  assign s_axi_awready = straps_loaded & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = straps_loaded & ~w_held & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // software controlled registers
  // ------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xtal_osc_enable     <= 1'b0;
      fast_rc_enable      <= 1'b0;
      clock_source_select <= 1'b0;
      double_speed_bypass <= DOUBLE_RESET;
      prescaler_reload    <= RELOAD_RESET;               // see R14
    end
    else
    begin
      if (!straps_loaded)
      begin
        // reset source follows the strap, not software
        xtal_osc_enable     <= cfg_reset_osc;            // see R13
        fast_rc_enable      <= ~cfg_reset_osc;           // see R13
        clock_source_select <= cfg_reset_osc;            // see R9
      end
      else if (wr_osc)
      begin
        xtal_osc_enable     <= w_data[XTAL_EN_BIT];      // see R4
        fast_rc_enable      <= w_data[FAST_EN_BIT];      // see R5
        clock_source_select <= w_data[SRC_SEL_BIT];      // see R6
      end
      if (wr_speed)
        double_speed_bypass <= w_data[DOUBLE_BIT];       // see R2
      if (wr_reload)
        prescaler_reload    <= w_data[7:0];              // see R1
    end
  end

  // ------------------------------------------------------------------
  // oscillator gating and source choice
  // ------------------------------------------------------------------
  wire        backup_active = ~xtal_osc_enable & ~fast_rc_enable;
  wire        xtal_gated    = crystal_oscillator & xtal_osc_enable; // see R4
  wire        fast_gated    = fast_rc_oscillator & fast_rc_enable;  // see R5
  wire        slow_gated    = slow_rc_oscillator & ~slow_rc_disable;
  wire [2:0]  src_levels    = {slow_gated, fast_gated, xtal_gated};
  wire src_t  want_src      = backup_active       ? SRC_SLOW :      // see R7
                              clock_source_select ? SRC_XTAL :      // see R12
                                                    SRC_FAST;       // see R6
  src_t       cur_src;
  logic       switch_pending;

  sel_clk_if  src_link ();

  glitchless_select u_select
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .src_level (src_levels),
    .want      (want_src),
    .current   (cur_src),
    .pending   (switch_pending),
    .out       (src_link.source)
  );

  // ------------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------------
  logic int_level;
  logic int_rise;

  clock_prescaler #(.RELOAD_W(8)) u_prescaler
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .reload    (prescaler_reload),
    .bypass    (double_speed_bypass),
    .src       (src_link.sink),
    .int_level (int_level),
    .int_rise  (int_rise)
  );

  // ------------------------------------------------------------------
  // machine cycle timing
  // ------------------------------------------------------------------
  // six internal periods per machine cycle: 6 source periods in bypass,
  // 12 to 256*12 source periods through the prescaler
  logic [2:0] phase;
  localparam logic [2:0] LAST_PHASE = 3'(MACHINE_PERIODS - 1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase         <= 3'h0;
      machine_cycle <= 1'b0;
      cpu_clk       <= 1'b0;
    end
    else
    begin
      cpu_clk       <= int_level;                        // see R1
      machine_cycle <= 1'b0;
      if (int_rise)
      begin
        if (phase == LAST_PHASE)
        begin
          phase         <= 3'h0;
          machine_cycle <= 1'b1;                         // see R3
        end
        else
          phase <= phase + 3'h1;                         // see R2
      end
    end
  end

  // ------------------------------------------------------------------
  // oscillator and pin outputs
  // ------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xtal_osc_run          <= 1'b0;
      fast_rc_run           <= 1'b0;
      slow_rc_run           <= 1'b0;
      watchdog_clk          <= 1'b0;
      crystal_pins_released <= 1'b1;
    end
    else
    begin
      xtal_osc_run          <= xtal_osc_enable;          // see R4
      fast_rc_run           <= fast_rc_enable;           // see R5
      slow_rc_run           <= ~slow_rc_disable;         // see R8
      watchdog_clk          <= slow_gated;               // see R8
      crystal_pins_released <= ~(xtal_osc_enable &
                                 clock_source_select);   // see R11
    end
  end

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  wire [7:0] status_byte;
  assign status_byte[ST_SRC_LSB+1:ST_SRC_LSB] = cur_src;
  assign status_byte[ST_BACKUP_BIT]  = cur_src == SRC_SLOW;
  assign status_byte[ST_STRAP_BIT]   = strap_reset_osc;
  assign status_byte[ST_GAIN_BIT]    = crystal_gain_select;
  assign status_byte[ST_SLOWOFF_BIT] = slow_rc_disable;
  assign status_byte[ST_PINS_BIT]    = crystal_pins_released;
  assign status_byte[ST_PEND_BIT]    = switch_pending;

  wire [7:0] osc_byte = {5'h00, clock_source_select, fast_rc_enable,
                         xtal_osc_enable};
  wire [7:0] read_byte =
    (s_axi_araddr == OSC_CTRL_ADDR)   ? osc_byte :
    (s_axi_araddr == SPEED_CTRL_ADDR) ? {7'h00, double_speed_bypass} :
    (s_axi_araddr == RELOAD_ADDR)     ? prescaler_reload :
    (s_axi_araddr == CLK_STATUS_ADDR) ? status_byte : 8'h00;

  assign s_axi_arready = straps_loaded & ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, read_byte};
      s_axi_rresp  <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule
`default_nettype wire

// ===== core/clock_pkg.sv
// constants of the clock selector and prescaler block
// assumes a 20 MHz bus clock and a 32-bit AXI4-Lite register port
package clock_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OSC_CTRL_ADDR    = 8'h00;
  localparam logic [7:0] SPEED_CTRL_ADDR  = 8'h04;
  localparam logic [7:0] RELOAD_ADDR      = 8'h08;
  localparam logic [7:0] CLK_STATUS_ADDR  = 8'h0C;

  // oscillator_control fields
  localparam int XTAL_EN_BIT   = 0;
  localparam int FAST_EN_BIT   = 1;
  localparam int SRC_SEL_BIT   = 2;
  // speed control field
  localparam int DOUBLE_BIT    = 0;
  // status fields
  localparam int ST_SRC_LSB    = 0;
  localparam int ST_BACKUP_BIT = 2;
  localparam int ST_STRAP_BIT  = 3;
  localparam int ST_GAIN_BIT   = 4;
  localparam int ST_SLOWOFF_BIT= 5;
  localparam int ST_PINS_BIT   = 6;
  localparam int ST_PEND_BIT   = 7;

  // ------------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------------
  localparam logic [7:0] RELOAD_RESET   = 8'hFF;
  localparam logic       DOUBLE_RESET   = 1'b0;
  localparam int         MACHINE_PERIODS= 6;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {SRC_XTAL, SRC_FAST, SRC_SLOW} src_t;

endpackage

// ===== core/sel_clk_if.sv
// carries the selected source clock level from selector to prescaler
// assumes both ends run on the same bus clock
`timescale 1ns/100ps
`default_nettype none
interface sel_clk_if;
  logic level;
  logic rise;

  modport source
  (
    output level,
    output rise
  );
  modport sink
  (
    input  level,
    input  rise
  );
endinterface
`default_nettype wire

// ===== core/glitchless_select.sv
// glitch-free changeover between three sampled oscillator levels
// assumes oscillator levels are synchronous samples of the bus clock
`timescale 1ns/100ps
`default_nettype none
module glitchless_select
  import clock_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [2:0]   src_level,
  input  wire clock_pkg::src_t want,
  output clock_pkg::src_t   current,
  output logic              pending,
  sel_clk_if.source         out
);
  typedef enum logic {RUN, PARK} sel_state_t;

  sel_state_t state;
  logic       level_q;
  logic       level_prev;
  wire        cur_level  = src_level[current];
  wire        want_level = src_level[want];

  // leave the old source only in its low phase, join the new one only in
  // its low phase, so the output never shows a runt pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state      <= RUN;
      current    <= SRC_FAST;
      level_q    <= 1'b0;
      level_prev <= 1'b0;
    end
    else
    begin
      level_prev <= level_q;
      case (state)
        RUN:
        begin
          level_q <= cur_level;
          if (want != current && !cur_level)
            state <= PARK;                               // see R15
        end
        PARK:
        begin
          level_q <= 1'b0;
          if (!want_level)
          begin
            current <= want;                             // see R15
            state   <= RUN;
          end
        end
        default: state <= RUN;
      endcase
    end
  end

  assign pending   = (state == PARK) || (want != current);
  assign out.level = level_q;
  assign out.rise  = level_q & ~level_prev;
endmodule
`default_nettype wire

// ===== core/clock_prescaler.sv
// divides the selected source by 2*(256-reload) or passes it in bypass
// assumes the source level arrives as a sampled level with a rise pulse
`timescale 1ns/100ps
`default_nettype none
module clock_prescaler
#(
  parameter int RELOAD_W = 8
)
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [RELOAD_W-1:0] reload,
  input  wire logic                bypass,
  sel_clk_if.sink                  src,
  output logic                     int_level,
  output logic                     int_rise
);
  generate
    if (RELOAD_W < 1 || RELOAD_W > 16)
    begin : g_bad_width
      $error("reload width out of range");
    end
  endgenerate

  logic [RELOAD_W-1:0] count;
  logic                div_level;
  logic                level_prev;
  wire  [RELOAD_W-1:0] last_count = ~reload;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count      <= '0;
      div_level  <= 1'b0;
      int_level  <= 1'b0;
      level_prev <= 1'b0;
    end
    else
    begin
      level_prev <= int_level;
      if (bypass)
      begin
        count     <= '0;                                 // see R2
        int_level <= src.level;                          // see R2
      end
      else
      begin
        int_level <= div_level;                          // see R1
        if (src.rise)
        begin
          // half period is 256-reload source periods
          if (count >= last_count)
          begin
            count     <= '0;                             // see R16
            div_level <= ~div_level;                     // see R14
          end
          else
            count <= count + 1'b1;
        end
      end
    end
  end

  assign int_rise = int_level & ~level_prev;
endmodule
`default_nettype wire

// ===== bench/clock_system_assertions.sv
// port-level checks of the clock system top, bound into it
// assumes one clock domain and straps that change only in reset
`timescale 1ns/100ps
`default_nettype none
module clock_system_assertions
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cfg_crystal_gain,
  input wire logic        cfg_slow_rc_disable,
  input wire logic        slow_rc_oscillator,
  input wire logic        xtal_osc_run,
  input wire logic        slow_rc_run,
  input wire logic        crystal_gain_select,
  input wire logic        crystal_pins_released,
  input wire logic        watchdog_clk,
  input wire logic        cpu_clk,
  input wire logic        machine_cycle
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // --------
  // helpers
  // --------
  logic [1:0] up;
  logic [3:0] rises;
  logic       prev_clk;
  wire        clk_up = cpu_clk & ~prev_clk;
  wire [3:0]  next_rises = machine_cycle ? {3'b000, clk_up} : rises + clk_up;

  always_ff @(posedge aclk)
  begin
    up       <= !aresetn ? 2'b00 : (up == 2'b11 ? up : up + 2'b01);
    rises    <= !aresetn ? 4'h0 : next_rises;
    prev_clk <= !aresetn ? 1'b0 : cpu_clk;
  end

  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // --------
  // checks
  // --------
  a_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    crystal_pins_released && !cpu_clk && !s_axi_bvalid)
    else $error("outputs not idle in reset");
  a_slow_enable: assert property (up == 2'b11 |->
    slow_rc_run == !cfg_slow_rc_disable) else $error("slow rc run");
  a_watchdog_feed: assert property (up == 2'b11 |-> watchdog_clk ==
    ($past(slow_rc_oscillator) & ~cfg_slow_rc_disable))
    else $error("watchdog clock");
  a_gain_copy: assert property (up == 2'b11 |->
    crystal_gain_select == cfg_crystal_gain) else $error("gain");
  a_pins_taken: assert property (!crystal_pins_released |-> xtal_osc_run)
    else $error("pins held with crystal off");
  a_machine_rate: assert property (rises <= 4'h6)
    else $error("machine cycle missing");
  a_machine_pulse: assert property (machine_cycle |=> !machine_cycle)
    else $error("machine pulse too long");
endmodule

bind clock_system clock_system_assertions clock_system_assertions_i
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .cfg_crystal_gain, .cfg_slow_rc_disable,
  .slow_rc_oscillator, .xtal_osc_run, .slow_rc_run, .crystal_gain_select,
  .crystal_pins_released, .watchdog_clk, .cpu_clk, .machine_cycle
);
`default_nettype wire

// ===== bench/osc_model.sv
// behavioural oscillators on the far side of the clock system
// assumes run enables from the design; a stopped oscillator stands low
`timescale 1ns/100ps
`default_nettype none
module osc_model
#(
  parameter int XH = 2,
  parameter int FH = 3,
  parameter int SH = 5
)
(
  input  wire logic aclk,
  input  wire logic xtal_run,
  input  wire logic fast_run,
  input  wire logic slow_run,
  output logic      xtal,
  output logic      fast,
  output logic      slow
);
  int xc = 0;
  int fc = 0;
  int sc = 0;

  always @(posedge aclk)
  begin
    xc <= xtal_run ? (xc + 1) % (2 * XH) : 0;
    fc <= fast_run ? (fc + 1) % (2 * FH) : 0;
    sc <= slow_run ? (sc + 1) % (2 * SH) : 0;
  end

  assign xtal = xtal_run && xc >= XH;
  assign fast = fast_run && fc >= FH;
  assign slow = slow_run && sc >= SH;
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench of the clock system over its register port
// assumes the oscillator model as far side and a 20 MHz bus clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import clock_pkg::*;
  localparam int XP = 4;
  localparam int FP = 6;
  localparam int SP = 10;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_clk;
  logic        cfg_reset_osc, cfg_crystal_gain, cfg_slow_rc_disable;
  logic        crystal_oscillator, fast_rc_oscillator, slow_rc_oscillator;
  logic        xtal_osc_run, fast_rc_run, slow_rc_run, crystal_gain_select;
  logic        crystal_pins_released, watchdog_clk, machine_cycle;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  rl [4] = '{8'hFF, 8'hFE, 8'h80, 8'h00};
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  int          p;

  clock_system clock_system_i
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cfg_reset_osc, .cfg_crystal_gain, .cfg_slow_rc_disable,
    .crystal_oscillator, .fast_rc_oscillator, .slow_rc_oscillator,
    .xtal_osc_run, .fast_rc_run, .slow_rc_run, .crystal_gain_select,
    .crystal_pins_released, .watchdog_clk, .cpu_clk, .machine_cycle
  );

  osc_model osc_model_i
  (
    .aclk, .xtal_run(xtal_osc_run), .fast_run(fast_rc_run),
    .slow_run(slow_rc_run), .xtal(crystal_oscillator),
    .fast(fast_rc_oscillator), .slow(slow_rc_oscillator)
  );

  // --------
  // clock, timeout, report
  // --------
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      mismatches++;
      $display("ERROR at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  // --------
  // bus cycles and measurement
  // --------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    check_word(32'(s_axi_bresp), 32'(RESP_OKAY));
  endtask

  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // cycles from second to third event
  task automatic period(input bit mc);
    int n;
    int k;
    logic prev;
    n = 0;
    k = 0;
    p = 0;
    prev = cpu_clk;
    while (k < 3 && n < 8000)
    begin
      @(posedge aclk);
      n++;
      if (k == 2)
        p++;
      if (mc ? machine_cycle : (cpu_clk && !prev))
        k++;
      prev = cpu_clk;
    end
  endtask

  task automatic do_reset(input logic strap);
    aresetn <= 1'b0;
    cfg_reset_osc <= strap;
    cfg_crystal_gain <= strap;
    cfg_slow_rc_disable <= !strap;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
  endtask

  function automatic logic [31:0] stat(input int src, input bit bk,
    input bit strap, input bit pins);
    stat = 32'(src) | (32'(bk) << ST_BACKUP_BIT) | (32'(strap) << ST_STRAP_BIT)
      | (32'(strap) << ST_GAIN_BIT) | (32'(pins) << ST_PINS_BIT)
      | (32'(!strap) << ST_SLOWOFF_BIT);
  endfunction

  // --------
  // tests
  // --------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    do_reset(1'b1);
    axi_read(OSC_CTRL_ADDR);
    check_word(rd, 32'h0000_0005);
    axi_read(CLK_STATUS_ADDR);
    check_word(rd, stat(SRC_XTAL, 0, 1, 0));
    axi_read(RELOAD_ADDR);
    check_word(rd, 32'h0000_00FF);
    axi_read(8'h10);
    check_word(32'(rs), 32'(RESP_SLVERR));
    check_word(32'(xtal_osc_run), 32'h0000_0001);
    foreach (rl[i])
    begin
      axi_write(RELOAD_ADDR, {24'h00_0000, rl[i]});
      period(1'b0);
      check_count(p, 2 * (256 - int'(rl[i])) * XP);
    end
    axi_write(RELOAD_ADDR, 32'h0000_00FF);
    period(1'b1);
    check_count(p, 12 * XP);
    axi_write(SPEED_CTRL_ADDR, 32'h0000_0001);
    period(1'b0);
    check_count(p, XP);
    period(1'b1);
    check_count(p, MACHINE_PERIODS * XP);
    axi_write(OSC_CTRL_ADDR, 32'h0000_0003);
    repeat (40) @(posedge aclk);
    axi_read(CLK_STATUS_ADDR);
    check_word(rd, stat(SRC_FAST, 0, 1, 1));
    period(1'b0);
    check_count(p, FP);
    axi_write(OSC_CTRL_ADDR, 32'h0000_0007);
    repeat (40) @(posedge aclk);
    axi_read(CLK_STATUS_ADDR);
    check_word(rd, stat(SRC_XTAL, 0, 1, 0));
    axi_write(OSC_CTRL_ADDR, 32'h0000_0000);
    repeat (40) @(posedge aclk);
    axi_read(CLK_STATUS_ADDR);
    check_word(rd, stat(SRC_SLOW, 1, 1, 1));
    check_word(32'(fast_rc_run), 32'h0000_0000);
    period(1'b0);
    check_count(p, SP);
    do_reset(1'b0);
    axi_read(OSC_CTRL_ADDR);
    check_word(rd, 32'h0000_0002);
    axi_read(CLK_STATUS_ADDR);
    check_word(rd, stat(SRC_FAST, 0, 0, 1));
    close_out();
  end
endmodule
`default_nettype wire
